/* File: logic/pmc_macrocells.sv */
// Eight configurable output macrocells with mode routing and an AXI4-Lite
// register slave.
//
// Contract
// - Power-up reset clears all registers low.
// - Software preloads each register high or low.
// - Secured device refuses verify and preload.
// - Sixty-four signature bits always readable, writable.
// - Undriven pins read high to array.
// - Eight macrocells, four configurable kinds each.
// - Three global modes: registered, complex, simple.
// - Registered mode: dedicated pins are clock, enable.
// - Complex mode: dedicated pins use outer feedback.
// - Simple mode: adjacent feedback, inner cells output.
// - Registered cell: shared clock, enable, eight terms.
// - Combinatorial cell: one enable term, seven summed.
// - Input cell keeps its driver disabled.
// - Complex mode: outer cells output only.
// - Simple mode: eight terms, inner always enabled.
//
// Added by the designer: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module pmc_macrocells #(
  parameter int NCELL = 8,
  parameter int AW = 8
) (
  // System clock and asynchronous power-up reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // AXI4-Lite write address channel.
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data channel.
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response channel.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address channel.
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data channel.
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Dedicated clock pin and active-low enable pin, with external drive.
  input wire logic clk_pin_in,
  input wire logic clk_pin_ext_en,
  input wire logic oe_n_pin_in,
  input wire logic oe_n_pin_ext_en,
  // Macrocell pins: board side level and drive, device side drive.
  input wire pmc_pkg::pmc_pins_t io_pins,
  output pmc_pkg::pmc_drive_t io_drive,
  // Logic array: product terms in, term 0 is the enable term of combinatorial outputs; registered-mode register cells and simple mode sum it.
  input wire logic [8*NCELL-1:0] array_pt,
  // Logic array: feedback and dedicated-pin inputs out.
  output logic [NCELL-1:0] array_fb,
  output logic array_clk_pin,
  output logic array_oe_pin
);

  // Two-flop synchronisers for every pin input; stage one feeds stage two only.
  localparam int NSYNC = 2 * NCELL + 4;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  wire [NSYNC-1:0] sync_in = {io_pins.ext_en, io_pins.lvl, clk_pin_ext_en,
                              clk_pin_in, oe_n_pin_ext_en, oe_n_pin_in};

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= sync_in;
      sync2_r <= sync1_r;
    end
  end

  // Pin levels as the array sees them; an undriven pin floats high.
  wire oe_n_lvl = sync2_r[1] ? sync2_r[0] : 1'b1;
  wire clk_lvl = sync2_r[3] ? sync2_r[2] : 1'b1;
  wire [NCELL-1:0] io_lvl_s = sync2_r[4 +: NCELL];
  wire [NCELL-1:0] io_ext_s = sync2_r[4 + NCELL +: NCELL];
  logic [NCELL-1:0] pin_lvl;

  // Control and status state.
  logic [1:0] mode_r;
  logic fuse_r;
  logic [2*NCELL-1:0] cfg_r;
  logic [NCELL-1:0] q_r;
  logic [NCELL-1:0] q_nxt;
  logic refused_r;
  logic clk_prev_r;
  logic [5:0] por_cnt_r;
  wire por_busy = por_cnt_r != 6'(pmc_pkg::POWER_UP_RESET_CYC);
  wire pmc_pkg::pmc_mode_t mode = pmc_pkg::pmc_mode_t'(mode_r);
  wire is_reg = mode == pmc_pkg::MODE_REGISTERED;
  wire is_cpx = mode == pmc_pkg::MODE_COMPLEX;

  // Clock pin rise, ignored until the power-up interval has run out.
  wire clk_rise = clk_lvl && !clk_prev_r && !por_busy;

  // Power-up interval counter; the clock pin is ignored while it runs.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      por_cnt_r <= '0;
      clk_prev_r <= 1'b1; // Matches the pulled-up idle clock pin.
    end else begin
      if (por_busy) begin
        por_cnt_r <= por_cnt_r + 6'h01;
      end
      clk_prev_r <= clk_lvl;
    end
  end

  // Dedicated pins reach the array only outside registered mode.
  assign array_clk_pin = is_reg ? 1'b0 : clk_lvl;
  assign array_oe_pin = is_reg ? 1'b0 : oe_n_lvl;

  // Per-cell output, enable and feedback selection.
  logic [NCELL-1:0] out_c;
  logic [NCELL-1:0] oe_c;
  logic [NCELL-1:0] fb_c;
  logic [NCELL-1:0] d_c;

  genvar g;
  generate
    for (g = 0; g < NCELL; g++) begin : g_cell
      wire [7:0] pt = array_pt[8*g +: 8];
      wire sum8 = |pt;
      wire sum7 = |pt[7:1];
      wire pte = pt[0];
      wire pmc_pkg::pmc_cell_t kind = pmc_pkg::pmc_cell_t'(cfg_r[2*g +: 2]);
      wire outer = (g == 0) || (g == NCELL - 1);
      wire inner = (g == NCELL/2 - 1) || (g == NCELL/2);
      // Simple-mode feedback comes from the neighbour toward the centre.
      localparam int ADJ = (g < NCELL/2) ? g + 1 : g - 1;
      // Complex mode hands the outer feedback to the dedicated pins.
      wire cpx_outer_fb = (g == NCELL - 1) ? clk_lvl : oe_n_lvl;

      // Pin level seen back: board drive, own drive, else pull-up.
      assign pin_lvl[g] = io_ext_s[g] ? io_lvl_s[g] :
                          (io_drive.oe[g] ? io_drive.val[g] : 1'b1);
      // Register input: eight summed terms.
      assign d_c[g] = sum8;

      always_comb begin
        out_c[g] = 1'b0;
        oe_c[g] = 1'b0;
        fb_c[g] = 1'b0;
        case (mode)
          pmc_pkg::MODE_REGISTERED: begin
            if (kind == pmc_pkg::CELL_REG) begin
              // Shared enable pin, pin shows inverted register.
              out_c[g] = ~q_r[g];
              oe_c[g] = ~oe_n_lvl;
              fb_c[g] = q_r[g];
            end else if (kind == pmc_pkg::CELL_INPUT) begin
              oe_c[g] = 1'b0;
              fb_c[g] = pin_lvl[g];
            end else begin
              out_c[g] = sum7;
              oe_c[g] = pte;
              fb_c[g] = (kind == pmc_pkg::CELL_COMB_IO) ? pin_lvl[g] : 1'b0;
            end
          end
          pmc_pkg::MODE_COMPLEX: begin
            if (outer) begin
              // Outer cells are outputs; their feedback carries a pin.
              out_c[g] = sum7;
              oe_c[g] = pte;
              fb_c[g] = cpx_outer_fb;
            end else if (kind == pmc_pkg::CELL_INPUT) begin
              oe_c[g] = 1'b0;
              fb_c[g] = pin_lvl[g];
            end else begin
              out_c[g] = sum7;
              oe_c[g] = pte;
              fb_c[g] = pin_lvl[g];
            end
          end
          pmc_pkg::MODE_SIMPLE: begin
            out_c[g] = sum8;
            if (inner) begin
              // Inner cells always drive and feed nothing back.
              oe_c[g] = 1'b1;
              fb_c[g] = 1'b0;
            end else begin
              oe_c[g] = kind != pmc_pkg::CELL_INPUT;
              fb_c[g] = pin_lvl[ADJ];
            end
          end
          default: begin
            out_c[g] = 1'b0;
            oe_c[g] = 1'b0;
            fb_c[g] = 1'b0;
          end
        endcase
      end
    end
  endgenerate

  // Register-bus handshakes and address decode.
  logic aw_got_r;
  logic w_got_r;
  logic [AW-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic rd_pend_r;
  logic [AW-1:0] araddr_r;
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready = !w_got_r && !s_axi_bvalid;
  assign s_axi_arready = !rd_pend_r && !s_axi_rvalid;
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  wire wr_go = aw_got_r && w_got_r && !s_axi_bvalid;

  wire wa_ctrl = awaddr_r == pmc_pkg::REG_CTRL_OFS;
  wire wa_cfg = awaddr_r == pmc_pkg::REG_CELL_CFG_OFS;
  wire wa_pre = awaddr_r == pmc_pkg::REG_PRELOAD_OFS;
  wire wa_stat = awaddr_r == pmc_pkg::REG_STATUS_OFS;
  wire wa_siglo = awaddr_r == pmc_pkg::REG_SIG_LO_OFS;
  wire wa_sighi = awaddr_r == pmc_pkg::REG_SIG_HI_OFS;
  wire wa_hit = wa_ctrl | wa_cfg | wa_pre | wa_stat | wa_siglo | wa_sighi;
  wire [3:0] wstrb_r_lo;

  // Preload request: refused once the security fuse is set.
  wire pre_req = wr_go && wa_pre;
  wire pre_ok = pre_req && !fuse_r;
  wire [NCELL-1:0] pre_mask = wdata_r[pmc_pkg::PRELOAD_MASK_LSB +: NCELL];
  wire [NCELL-1:0] pre_val = wdata_r[pmc_pkg::PRELOAD_VAL_LSB +: NCELL];
  wire refused_clr = wr_go && wa_stat && wdata_r[pmc_pkg::STAT_REFUSED_BIT];

  // Next register state: preload wins over a clock rise on the same cell.
  generate
    for (g = 0; g < NCELL; g++) begin : g_q
      wire kreg = cfg_r[2*g +: 2] == pmc_pkg::CELL_REG;
      assign q_nxt[g] = (pre_ok && pre_mask[g]) ? pre_val[g] :
                        (is_reg && kreg && clk_rise) ? d_c[g] :
                        q_r[g];
    end
  endgenerate

  // Byte-enable capture of write data; only control and configuration writes keep unselected bytes.
  logic [3:0] wstrb_r;
  assign wstrb_r_lo = wstrb_r;

  // Write channel capture and write response.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pmc_pkg::RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wa_hit ? pmc_pkg::RESP_OKAY : pmc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control, configuration, macrocell registers and refusal flag.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mode_r <= pmc_pkg::MODE_RST;
      fuse_r <= 1'b0;
      cfg_r <= pmc_pkg::CELL_CFG_RST;
      q_r <= pmc_pkg::CELL_Q_RST;
      refused_r <= 1'b0;
    end else begin
      q_r <= q_nxt;
      if (wr_go && wa_ctrl && wstrb_r_lo[0]) begin
        mode_r <= wdata_r[pmc_pkg::CTRL_MODE_LSB +: 2];
      end
      // The fuse only ever sets; reset alone clears it.
      if (wr_go && wa_ctrl && wstrb_r_lo[1] &&
          wdata_r[pmc_pkg::CTRL_FUSE_BIT]) begin
        fuse_r <= 1'b1;
      end
      if (wr_go && wa_cfg && wstrb_r_lo[0]) begin
        cfg_r[7:0] <= wdata_r[7:0];
      end
      if (wr_go && wa_cfg && wstrb_r_lo[1]) begin
        cfg_r[15:8] <= wdata_r[15:8];
      end
      // A new refusal wins over a clear in the same cycle.
      if (pre_req && fuse_r) begin
        refused_r <= 1'b1;
      end else if (refused_clr) begin
        refused_r <= 1'b0;
      end
    end
  end

  // Signature words stay writable and readable regardless of the fuse.
  logic [31:0] sig_rd;
  wire sig_wr = wr_go && (wa_siglo || wa_sighi);
  wire ra_sig = s_axi_araddr == pmc_pkg::REG_SIG_HI_OFS;

  pmc_sig_mem #(
    .WORDS(2),
    .WIDTH(32)
  ) u_sig (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .wr_en(sig_wr),
    .wr_addr(wa_sighi),
    .wr_data(wdata_r),
    .rd_addr(ra_sig),
    .rd_data(sig_rd)
  );

  // Read decode; configuration readback is blanked once secured.
  wire [31:0] stat_word = {21'h0, refused_r, fuse_r, por_busy, q_r};
  wire [31:0] cfg_word = fuse_r ? 32'h0 : {16'h0, cfg_r};
  wire [31:0] ctrl_word = {23'h0, fuse_r, 6'h0, mode_r};
  wire ra_ctrl = araddr_r == pmc_pkg::REG_CTRL_OFS;
  wire ra_cfg = araddr_r == pmc_pkg::REG_CELL_CFG_OFS;
  wire ra_pre = araddr_r == pmc_pkg::REG_PRELOAD_OFS;
  wire ra_stat = araddr_r == pmc_pkg::REG_STATUS_OFS;
  wire ra_any_sig = (araddr_r == pmc_pkg::REG_SIG_LO_OFS) ||
                    (araddr_r == pmc_pkg::REG_SIG_HI_OFS);
  wire ra_hit = ra_ctrl | ra_cfg | ra_pre | ra_stat | ra_any_sig;
  wire [31:0] rd_mux = ra_ctrl ? ctrl_word :
                       ra_cfg ? cfg_word :
                       ra_stat ? stat_word :
                       ra_any_sig ? sig_rd : 32'h0;

  // Read channel: address taken, data answered one cycle later.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_pend_r <= 1'b0;
      araddr_r <= '0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= pmc_pkg::RESP_OKAY;
    end else begin
      if (ar_hs) begin
        rd_pend_r <= 1'b1;
        araddr_r <= s_axi_araddr;
      end
      if (rd_pend_r) begin
        rd_pend_r <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= ra_hit ? pmc_pkg::RESP_OKAY : pmc_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Pin drive and array feedback leave through flip-flops.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      io_drive <= '0;
      array_fb <= '0;
    end else begin
      io_drive.val <= out_c;
      io_drive.oe <= oe_c;
      array_fb <= fb_c;
    end
  end

endmodule

/* File: logic/pmc_pkg.sv */
// Shared constants, register map and types of the macrocell output logic.
package pmc_pkg;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] REG_CTRL_OFS = 8'h00;
  localparam logic [7:0] REG_CELL_CFG_OFS = 8'h04;
  localparam logic [7:0] REG_PRELOAD_OFS = 8'h08;
  localparam logic [7:0] REG_STATUS_OFS = 8'h0C;
  localparam logic [7:0] REG_SIG_LO_OFS = 8'h10;
  localparam logic [7:0] REG_SIG_HI_OFS = 8'h14;

  // Field positions in the control register.
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_FUSE_BIT = 8;

  // Field positions in the preload register.
  localparam int PRELOAD_MASK_LSB = 0;
  localparam int PRELOAD_VAL_LSB = 8;

  // Field positions in the status register.
  localparam int STAT_Q_LSB = 0;
  localparam int STAT_POR_BIT = 8;
  localparam int STAT_SEC_BIT = 9;
  localparam int STAT_REFUSED_BIT = 10;

  // Reset values.
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [15:0] CELL_CFG_RST = 16'h0000;
  localparam logic [7:0] CELL_Q_RST = 8'h00;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing: power-up reset interval and system clock period.
  localparam int POWER_UP_RESET_TIME_NS = 1000;
  localparam int CLK_PERIOD_NS = 25;
  // Longest time, so it rounds down to whole cycles.
  localparam int POWER_UP_RESET_CYC = POWER_UP_RESET_TIME_NS / CLK_PERIOD_NS;

  // Global operating mode of the device.
  typedef enum logic [1:0] {
    MODE_REGISTERED,
    MODE_COMPLEX,
    MODE_SIMPLE,
    MODE_UNUSED
  } pmc_mode_t;

  // Per-macrocell output_macrocell_config kind.
  typedef enum logic [1:0] {
    CELL_REG,
    CELL_COMB_IO,
    CELL_COMB_OUT,
    CELL_INPUT
  } pmc_cell_t;

  // Eight-wide pin group seen from the board: level and external drive.
  typedef struct packed {
    logic [7:0] ext_en;
    logic [7:0] lvl;
  } pmc_pins_t;

  // Drive of the eight macrocell pins: value and output enable.
  typedef struct packed {
    logic [7:0] oe;
    logic [7:0] val;
  } pmc_drive_t;

endpackage

/* File: logic/pmc_sig_mem.sv */
// Two-word user signature store with a registered read port.
`timescale 1ns/1ps
module pmc_sig_mem #(
  parameter int WORDS = 2,
  parameter int WIDTH = 32
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // Write port.
  input wire logic wr_en,
  input wire logic [$clog2(WORDS)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read port.
  input wire logic [$clog2(WORDS)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  // Storage words, cleared at reset.
  logic [WIDTH-1:0] mem_r [WORDS];

  // Writes store a word; the read word is registered every cycle.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < WORDS; i++) begin
        mem_r[i] <= '0;
      end
      rd_data <= '0;
    end else begin
      if (wr_en) begin
        mem_r[wr_addr] <= wr_data;
      end
      rd_data <= mem_r[rd_addr];
    end
  end

endmodule

/* File: testbench/pmc_macrocells_monitor.sv */
// Port checker of the macrocell output logic.
`timescale 1ns/1ps
module pmc_macrocells_monitor #(
  parameter int NCELL = 8,
  parameter int AW = 8
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // Write channels.
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read channels.
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pin drive and dedicated-pin array inputs.
  input wire pmc_pkg::pmc_drive_t io_drive,
  input wire logic array_clk_pin,
  input wire logic array_oe_pin
);
  logic [1:0] mode_r; // Mode last written.
  logic [15:0] cfg_r; // Cell kinds last written.
  logic [2:0] age_r; // Cycles since the last write, saturating at seven.
  logic [7:0] in_mask; // Cells set up as dedicated inputs.
  // A write is seen when both halves are taken at one edge.
  wire wr_hit = s_axi_awvalid && s_axi_awready &&
                s_axi_wvalid && s_axi_wready;
  wire ctrl_hit = wr_hit && s_axi_awaddr == pmc_pkg::REG_CTRL_OFS;
  wire cfg_hit = wr_hit && s_axi_awaddr == pmc_pkg::REG_CELL_CFG_OFS;
  // Follows the configuration from the bus traffic.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mode_r <= 2'h0;
      cfg_r <= 16'h0000;
      age_r <= 3'h0;
    end else if (wr_hit) begin
      if (ctrl_hit) mode_r <= s_axi_wdata[1:0];
      if (cfg_hit) cfg_r <= s_axi_wdata[15:0];
      age_r <= 3'h0;
    end else if (age_r != 3'h7) begin
      age_r <= age_r + 3'h1;
    end
  end
  // Marks the cells whose kind is input.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      in_mask[i] = cfg_r[2*i+:2] == 2'h3;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  AST_B_HOLD: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("Write response kept after taken.");
  AST_B_BLOCK: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("Write taken while a response waits.");
  AST_R_HOLD: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("Read data kept after taken.");
  AST_R_LAT: assert property (
    s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("Read answer late.");
  AST_AR_BLOCK: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("Read taken while data waits.");
  AST_ERR_ZERO: assert property (
    s_axi_rvalid && s_axi_rresp == pmc_pkg::RESP_SLVERR |-> s_axi_rdata == 0)
    else $error("Refused read carries data.");
  AST_PWRUP_CLEAR: assert property (
    $rose(arst_n) |-> io_drive.val == 8'h00 ##1 io_drive.val == 8'hFF)
    else $error("Outputs not high after power-up.");
  AST_REG_PINS: assert property (
    mode_r == 2'h0 && age_r == 3'h7 |-> !array_clk_pin && !array_oe_pin)
    else $error("Dedicated pin reached the array.");
  AST_INPUT_OFF: assert property (
    age_r == 3'h7 |-> (io_drive.oe & in_mask) == 8'h00)
    else $error("Input cell drives its pin.");
  AST_INNER_ON: assert property (
    mode_r == 2'h2 && age_r == 3'h7 |-> io_drive.oe[4:3] == 2'h3)
    else $error("Inner cell not enabled.");
  AST_ALL_OFF: assert property (
    mode_r == 2'h3 && age_r == 3'h7 |-> io_drive.oe == 8'h00)
    else $error("Unused mode drives a pin.");
endmodule

/* File: testbench/pmc_board_model.sv */
// Board model that drives the device pins and resolves their levels.
`timescale 1ns/1ps
module pmc_board_model (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // Requests from the bench.
  input wire logic [7:0] drv_en,
  input wire logic [7:0] drv_val,
  input wire logic oe_n_lvl,
  input wire logic clk_float,
  // Device drive seen on the pins.
  input wire pmc_pkg::pmc_drive_t io_drive,
  // Pin levels handed to the device.
  output pmc_pkg::pmc_pins_t io_pins,
  output logic clk_pin_in,
  output logic clk_pin_ext_en,
  output logic oe_n_pin_in,
  output logic oe_n_pin_ext_en
);
  logic clk_lvl = 1'b0; // Level the board puts on the clock pin.
  // Undriven pins rise to the pull-up; else the driver's level shows.
  always_comb begin
    io_pins.ext_en = drv_en;
    for (int i = 0; i < 8; i++) begin
      io_pins.lvl[i] = drv_en[i] ? drv_val[i] :
                       io_drive.oe[i] ? io_drive.val[i] : 1'b1;
    end
  end
  assign clk_pin_ext_en = !clk_float;
  assign clk_pin_in = clk_float ? 1'b1 : clk_lvl;
  assign oe_n_pin_ext_en = 1'b1;
  assign oe_n_pin_in = oe_n_lvl;
  // One clock-pin pulse; inputs settle first and reset keeps it low.
  task automatic pulse();
    repeat (4) @(posedge clk_sys);
    if (arst_n) clk_lvl <= 1'b1;
    repeat (4) @(posedge clk_sys);
    clk_lvl <= 1'b0;
  endtask
endmodule

/* File: testbench/pmc_macrocells_tb_top.sv */
// Self-checking bench of the macrocell output logic.
`timescale 1ns/1ps
module pmc_macrocells_tb_top;
  // Clock, reset and bus, idle at time zero.
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  // Array, pins and board requests.
  logic [63:0] array_pt = 64'h0;
  logic [7:0] array_fb, drv_en = 8'h00, drv_val = 8'h00;
  logic array_clk_pin, array_oe_pin, oe_n_lvl = 1'b0, clk_float = 1'b0;
  logic clk_pin_in, clk_pin_ext_en, oe_n_pin_in, oe_n_pin_ext_en;
  pmc_pkg::pmc_pins_t io_pins;
  pmc_pkg::pmc_drive_t io_drive;
  logic [31:0] sig_q[$]; // Signature words the model expects.
  int fail_count = 0;
  int samples_checked = 0;

  always #12.5 clk_sys = ~clk_sys;

  pmc_macrocells pmc_macrocells_inst (.*);
  pmc_board_model pmc_board_model_inst (.*);

  // Compares one result with the model and counts it.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("Checked %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // One write; both halves offered together, each dropped when taken.
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (!s_axi_bvalid && n < 50);
    r = s_axi_bresp;
    if (!s_axi_bvalid) begin
      fail_count++;
      conclude();
    end
  endtask

  // One read; the address waits for ready, then data is awaited.
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!s_axi_rvalid && n < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (!s_axi_rvalid) begin
      fail_count++;
      conclude();
    end
  endtask

  // Sum of each cell's product terms, past the enable term if asked.
  function automatic logic [7:0] sums(input logic [63:0] pt, input int sk);
    logic [7:0] s;
    for (int i = 0; i < 8; i++) s[i] = |(pt[8*i+:8] >> sk);
    return s;
  endfunction

  // Main sequence.
  initial begin
    logic [31:0] rd;
    logic [1:0] rs;
    logic [7:0] m, v;
    int qm;
    rd = $urandom(98);
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check(io_drive.val, 8'hFF);
    axi_read(pmc_pkg::REG_STATUS_OFS, rd, rs);
    check(rd, 32'h100);
    repeat (pmc_pkg::POWER_UP_RESET_CYC) @(posedge clk_sys);
    for (int a = 0; a < 16; a += 4) begin
      axi_read(8'(a), rd, rs);
      check(rd, 32'h0);
    end
    // Preload random states, then capture random terms on a pin pulse.
    qm = 0;
    repeat (3) begin
      m = 8'($urandom());
      v = 8'($urandom());
      qm = (qm & ~m) | (v & m);
      axi_write(pmc_pkg::REG_PRELOAD_OFS, {16'h0, v, m}, rs);
      axi_read(pmc_pkg::REG_STATUS_OFS, rd, rs);
      check(rd, qm);
      check(io_drive.val, {~qm[7:0]});
    end
    array_pt <= {$urandom(), $urandom()};
    pmc_board_model_inst.pulse();
    qm = sums(array_pt, 0);
    axi_read(pmc_pkg::REG_STATUS_OFS, rd, rs);
    check(rd, qm);
    check({io_drive.oe, io_drive.val}, {8'hFF, ~qm[7:0]});
    oe_n_lvl <= 1'b1;
    repeat (5) @(posedge clk_sys);
    check(io_drive.oe, 8'h00);
    // Input, combinatorial I/O and output cells beside registers.
    drv_en <= 8'h01;
    axi_write(pmc_pkg::REG_CELL_CFG_OFS, 32'h27, rs);
    repeat (3) begin
      array_pt <= {$urandom(), $urandom()};
      repeat (4) @(posedge clk_sys);
      v = sums(array_pt, 1);
      check(io_drive.oe, {5'h0, array_pt[16], array_pt[8], 1'b0});
      check(io_drive.val[2:1], v[2:1]);
    end
    // Simple mode with an input on cell one.
    axi_write(pmc_pkg::REG_CTRL_OFS, 32'h2, rs);
    axi_write(pmc_pkg::REG_CELL_CFG_OFS, 32'hAAAE, rs);
    drv_en <= 8'h02;
    repeat (3) begin
      drv_val <= 8'($urandom());
      array_pt <= {$urandom(), $urandom()};
      repeat (6) @(posedge clk_sys);
      v = sums(array_pt, 0);
      check(io_drive.val[4:3], v[4:3]);
      check(array_fb & 8'h1D, {5'h0, v[3], 1'b0, drv_val[1]});
    end
    // Complex mode with a floating clock pin, then the unused mode.
    axi_write(pmc_pkg::REG_CTRL_OFS, 32'h1, rs);
    clk_float <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      oe_n_lvl <= k[0];
      repeat (6) @(posedge clk_sys);
      check({array_fb[7], array_fb[0], array_clk_pin, array_oe_pin},
            {1'b1, k[0], 1'b1, k[0]});
    end
    check(io_drive.oe & 8'h81, {array_pt[56], 6'h0, array_pt[0]});
    clk_float <= 1'b0;
    axi_write(pmc_pkg::REG_CTRL_OFS, 32'h3, rs);
    repeat (8) @(posedge clk_sys);
    check(io_drive.oe, 8'h00);
    // Signature words and an unmapped place.
    repeat (2) sig_q.push_back($urandom());
    axi_write(pmc_pkg::REG_SIG_LO_OFS, sig_q[0], rs);
    axi_write(pmc_pkg::REG_SIG_HI_OFS, sig_q[1], rs);
    axi_read(8'h18, rd, rs);
    check(rd, 32'h0);
    check(rs, pmc_pkg::RESP_SLVERR);
    axi_write(8'h18, 32'h1, rs);
    check(rs, pmc_pkg::RESP_SLVERR);
    // Fuse set last; preload and verify are refused afterwards.
    axi_write(pmc_pkg::REG_CTRL_OFS, 32'h0, rs);
    qm = $urandom() & 32'hFF;
    axi_write(pmc_pkg::REG_PRELOAD_OFS, {16'h0, qm[7:0], 8'hFF}, rs);
    axi_write(pmc_pkg::REG_CTRL_OFS, 32'h100, rs);
    axi_write(pmc_pkg::REG_PRELOAD_OFS, {16'h0, ~qm[7:0], 8'hFF}, rs);
    check(rs, pmc_pkg::RESP_OKAY);
    axi_read(pmc_pkg::REG_STATUS_OFS, rd, rs);
    check(rd, 32'h600 | qm);
    axi_read(pmc_pkg::REG_CELL_CFG_OFS, rd, rs);
    check(rd, 32'h0);
    for (int k = 0; k < 2; k++) begin
      axi_read(8'(pmc_pkg::REG_SIG_LO_OFS + 4 * k), rd, rs);
      check(rd, sig_q[k]);
    end
    axi_write(pmc_pkg::REG_STATUS_OFS, 32'h400, rs);
    axi_read(pmc_pkg::REG_STATUS_OFS, rd, rs);
    check(rd, 32'h200 | qm);
    // A second power-up in mid-run.
    oe_n_lvl <= 1'b0;
    arst_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    axi_read(pmc_pkg::REG_STATUS_OFS, rd, rs);
    check(rd, 32'h100);
    conclude();
  end
endmodule

bind pmc_macrocells pmc_macrocells_monitor #(.NCELL(NCELL), .AW(AW))
  pmc_macrocells_monitor_inst (.*);
